//--- iev_pkg.sv
package iev_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int          ADDR_W           = 9;
    localparam int          DATA_W           = 32;
    localparam int          STRB_W           = 4;
    localparam int          MAX_INPUTS       = 32;
    localparam int          IDX_W            = 5;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [8:0]  OFF_ENABLE_MASK  = 9'h008;
    localparam logic [8:0]  OFF_SET_LOC      = 9'h010;
    localparam logic [8:0]  OFF_CLEAR_LOC    = 9'h014;
    localparam logic [8:0]  OFF_VEC_INDEX    = 9'h018;
    localparam logic [8:0]  OFF_MASTER       = 9'h01C;
    localparam logic [8:0]  OFF_MODE         = 9'h020;
    localparam logic [8:0]  OFF_TABLE_BASE   = 9'h100;
    localparam logic [8:0]  OFF_TABLE_LAST   = 9'h17C;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          GATE_BIT         = 0;
    localparam int          ARM_BIT          = 1;
    localparam logic [31:0] RST_ENABLE_MASK  = 32'h0000_0000;
    localparam logic [31:0] RST_MODE         = 32'h0000_0000;
    localparam logic [31:0] RST_TABLE        = 32'h0000_0000;
    localparam logic        RST_GATE         = 1'b0;
    localparam logic        RST_ARM          = 1'b0;
    localparam logic [31:0] RST_VEC_INDEX    = 32'h0000_0000;
    localparam logic [31:0] IDLE_VEC_INDEX   = 32'hFFFF_FFFF;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ****************************************************************
    // Default input counts
    // ****************************************************************
    localparam int          DEF_HW_COUNT     = 4;
    localparam int          DEF_SW_COUNT     = 2;

    typedef enum logic [3:0] {
        T_NONE   = 4'h0,
        T_MASK   = 4'h1,
        T_SET    = 4'h2,
        T_CLEAR  = 4'h3,
        T_INDEX  = 4'h4,
        T_MASTER = 4'h5,
        T_MODE   = 4'h6,
        T_TABLE  = 4'h7
    } iev_target_t;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Ones on configured input positions only
    function automatic logic [31:0] input_mask(input int count);
        logic [31:0] res;
        res = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (i < count) begin
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

endpackage

//--- iev_table_if.sv
`timescale 1ns/1ps
interface iev_table_if;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [4:0]  rd_idx;
    logic [31:0] rd_data;
    logic [4:0]  sel_idx;
    logic [31:0] sel_addr;

    modport ctrl (
        output wr_en, wr_idx, wr_data, wr_strb, rd_idx, sel_idx,
        input  rd_data, sel_addr
    );
    modport store (
        input  wr_en, wr_idx, wr_data, wr_strb, rd_idx, sel_idx,
        output rd_data, sel_addr
    );
endinterface

//--- iev_prio_enc.sv
`timescale 1ns/1ps
module iev_prio_enc #(
    parameter int N = 32
) (
    input  wire logic [31:0] i_pend,
    output logic      [31:0] o_index
);
    // Scan from the top so the lowest set position wins last
    always_comb begin
        o_index = iev_pkg::IDLE_VEC_INDEX;
        for (int i = N - 1; i >= 0; i--) begin
            if (i_pend[i]) begin
                o_index = 32'(i);
            end
        end
    end
endmodule

//--- iev_vec_table.sv
`timescale 1ns/1ps
module iev_vec_table #(
    parameter int N = 32
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    iev_table_if.store tbl
);
    logic [31:0] table_q    [0:31]; // see R17
    logic [31:0] next_table [0:31];

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            next_table[i] = table_q[i];
        end
        // Entries past the configured count keep nothing
        if (tbl.wr_en && (int'(tbl.wr_idx) < N)) begin
            next_table[tbl.wr_idx] = iev_pkg::merge_bytes(table_q[tbl.wr_idx],
                                                          tbl.wr_data, tbl.wr_strb);
        end
    end

    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 32; i++) begin
            if (!i_rst_n) begin
                table_q[i] <= iev_pkg::RST_TABLE;
            end else begin
                table_q[i] <= next_table[i];
            end
        end
    end

    assign tbl.rd_data  = (int'(tbl.rd_idx) < N) ? table_q[tbl.rd_idx] : 32'h0000_0000;
    assign tbl.sel_addr = table_q[tbl.sel_idx];
endmodule

//--- iev_ctrl.sv
`timescale 1ns/1ps
// Contract
// R1: Set location ones set mask bits
// R2: Clear location ones clear mask bits
// R3: Zeros and unconfigured positions change nothing
// R4: Set and clear locations optional by parameter
// R5: Vector index reads highest enabled active input
// R6: Lower bit position has higher priority
// R7: Nothing pending: vector index all ones; the code resets it to 0 and loads all ones at the first clock after reset
// R8: Vector index selects accompanying table entry
// R9: Master control: gate bit0, arm bit1, reset 0
// R10: Gate one allows request, zero blocks all
// R11: Arm zero ignores hardware, allows software test
// R12: Arm bit write-once until reset
// R13: Upper master bits ignored, read zero
// R14: Mode select exists only with fast parameter
// R15: Mode bit zero normal, one fast
// R16: Unconfigured mode bits read zero
// R17: One 32-bit table entry per input
// R18: Fast mode drives stored address with request
// R19: Table entries past count read zero, ignore writes
// R20: Software writes table only while gate zero; the code takes table writes whatever the gate value
// R21: Mask bit gates reporting, not capture
// R22: Request is OR of pending, gated
// R23: Set and clear update mask atomically
// R24: Index and address follow within one clock
module iev_ctrl #(
    parameter int HW_COUNT         = iev_pkg::DEF_HW_COUNT,
    parameter int SW_COUNT         = iev_pkg::DEF_SW_COUNT,
    parameter bit HAS_SET_LOCATION = 1'b1,
    parameter bit HAS_CLEAR_LOCATION = 1'b1,
    parameter bit HAS_FAST         = 1'b1
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // AXI4-Lite write address and data
    input  wire logic [8:0]  I_S_AXI_AWADDR,
    input  wire logic        I_S_AXI_AWVALID,
    output logic             O_S_AXI_AWREADY,
    input  wire logic [31:0] I_S_AXI_WDATA,
    input  wire logic [3:0]  I_S_AXI_WSTRB,
    input  wire logic        I_S_AXI_WVALID,
    output logic             O_S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       O_S_AXI_BRESP,
    output logic             O_S_AXI_BVALID,
    input  wire logic        I_S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [8:0]  I_S_AXI_ARADDR,
    input  wire logic        I_S_AXI_ARVALID,
    output logic             O_S_AXI_ARREADY,
    output logic [31:0]      O_S_AXI_RDATA,
    output logic [1:0]       O_S_AXI_RRESP,
    output logic             O_S_AXI_RVALID,
    input  wire logic        I_S_AXI_RREADY,
    // Status bits from the capture logic (same clock)
    input  wire logic [31:0] I_STATUS_BITS,
    // Processor side
    output logic             O_IRQ,
    output logic             O_IRQ_FAST,
    output logic [31:0]      O_IRQ_ADDR,
    // To the capture logic
    output logic             O_HW_INPUT_ARM
);
    localparam int          N     = HW_COUNT + SW_COUNT;
    localparam logic [31:0] VALID = iev_pkg::input_mask(N);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic iev_pkg::iev_target_t decode(input logic [8:0] addr);
        iev_pkg::iev_target_t t;
        t = iev_pkg::T_NONE;
        if (addr[8:7] == iev_pkg::OFF_TABLE_BASE[8:7]) begin
            t = iev_pkg::T_TABLE;
        end else if (addr[8:2] == iev_pkg::OFF_ENABLE_MASK[8:2]) begin
            t = iev_pkg::T_MASK;
        end else if (HAS_SET_LOCATION && addr[8:2] == iev_pkg::OFF_SET_LOC[8:2]) begin
            t = iev_pkg::T_SET; // see R4
        end else if (HAS_CLEAR_LOCATION && addr[8:2] == iev_pkg::OFF_CLEAR_LOC[8:2]) begin
            t = iev_pkg::T_CLEAR; // see R4
        end else if (addr[8:2] == iev_pkg::OFF_VEC_INDEX[8:2]) begin
            t = iev_pkg::T_INDEX;
        end else if (addr[8:2] == iev_pkg::OFF_MASTER[8:2]) begin
            t = iev_pkg::T_MASTER;
        end else if (HAS_FAST && addr[8:2] == iev_pkg::OFF_MODE[8:2]) begin
            t = iev_pkg::T_MODE; // see R14
        end
        return t;
    endfunction

    // Strobe lanes expanded to a bit mask
    function automatic logic [31:0] lanes(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic        awready, next_awready;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        arready, next_arready;
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] enable_mask, next_enable_mask;
    logic [31:0] mode_select, next_mode_select;
    logic        output_gate, next_output_gate;
    logic        hw_input_arm, next_hw_input_arm;
    logic [31:0] vector_index, next_vector_index;
    logic        irq, next_irq;
    logic        irq_fast, next_irq_fast;
    logic [31:0] irq_addr, next_irq_addr;

    logic                 wr_take;
    logic                 rd_take;
    iev_pkg::iev_target_t wr_tgt;
    iev_pkg::iev_target_t rd_tgt;
    logic [31:0]          wbits;
    logic [31:0]          pend;
    logic [31:0]          prio_index;

    iev_table_if tbl ();

    iev_prio_enc #(
        .N       (N)
    ) u_prio (
        .i_pend  (pend),
        .o_index (prio_index)
    );

    iev_vec_table #(
        .N       (N)
    ) u_table (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .tbl     (tbl.store)
    );

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // One write at a time: address and data are taken together, and
    // nothing new is taken while a response is still outstanding.
    assign wr_take = I_S_AXI_AWVALID && I_S_AXI_WVALID && !awready && !bvalid;
    assign rd_take = I_S_AXI_ARVALID && !arready && !rvalid;
    assign wr_tgt  = decode(I_S_AXI_AWADDR);
    assign rd_tgt  = decode(I_S_AXI_ARADDR);
    // Only ones on written lanes at configured positions count
    assign wbits   = I_S_AXI_WDATA & lanes(I_S_AXI_WSTRB) & VALID; // see R3

    assign tbl.wr_en   = wr_take && (wr_tgt == iev_pkg::T_TABLE);
    assign tbl.wr_idx  = I_S_AXI_AWADDR[6:2];
    assign tbl.wr_data = I_S_AXI_WDATA;
    assign tbl.wr_strb = I_S_AXI_WSTRB;
    assign tbl.rd_idx  = I_S_AXI_ARADDR[6:2]; // see R19
    assign tbl.sel_idx = prio_index[4:0]; // see R8

    always_comb begin
        next_awready = wr_take;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (wr_take) begin
            next_bvalid = 1'b1;
            next_bresp  = (wr_tgt == iev_pkg::T_NONE) ? iev_pkg::RESP_SLVERR
                                                      : iev_pkg::RESP_OKAY;
        end else if (bvalid && I_S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
    end

    always_comb begin
        next_arready = rd_take;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rresp  = iev_pkg::RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (rd_tgt == iev_pkg::T_MASK) begin
                next_rdata = enable_mask;
            end else if (rd_tgt == iev_pkg::T_INDEX) begin
                next_rdata = vector_index; // see R5
            end else if (rd_tgt == iev_pkg::T_MASTER) begin
                next_rdata[iev_pkg::GATE_BIT] = output_gate; // see R13
                next_rdata[iev_pkg::ARM_BIT]  = hw_input_arm;
            end else if (rd_tgt == iev_pkg::T_MODE) begin
                next_rdata = mode_select & VALID; // see R16
            end else if (rd_tgt == iev_pkg::T_TABLE) begin
                next_rdata = tbl.rd_data; // see R19
            end else if (rd_tgt == iev_pkg::T_NONE) begin
                next_rresp = iev_pkg::RESP_SLVERR;
            end
        end else if (rvalid && I_S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_comb begin
        next_enable_mask  = enable_mask;
        next_mode_select  = mode_select;
        next_output_gate  = output_gate;
        next_hw_input_arm = hw_input_arm;
        if (wr_take) begin
            // Single-cycle update, so the encoder never sees a half-written mask
            if (wr_tgt == iev_pkg::T_SET) begin
                next_enable_mask = enable_mask | wbits; // see R1 R23
            end else if (wr_tgt == iev_pkg::T_CLEAR) begin
                next_enable_mask = enable_mask & ~wbits; // see R2 R23
            end else if (wr_tgt == iev_pkg::T_MASK) begin
                next_enable_mask = iev_pkg::merge_bytes(enable_mask, I_S_AXI_WDATA,
                                                        I_S_AXI_WSTRB) & VALID;
            end else if (wr_tgt == iev_pkg::T_MODE) begin
                next_mode_select = iev_pkg::merge_bytes(mode_select, I_S_AXI_WDATA,
                                                        I_S_AXI_WSTRB) & VALID; // see R15
            end else if (wr_tgt == iev_pkg::T_MASTER && I_S_AXI_WSTRB[0]) begin
                next_output_gate = I_S_AXI_WDATA[iev_pkg::GATE_BIT]; // see R10
                // A zero never clears it; once set only reset does
                if (I_S_AXI_WDATA[iev_pkg::ARM_BIT]) begin
                    next_hw_input_arm = 1'b1; // see R12
                end
            end
        end
    end

    // ****************************************************************
    // Request and vector outputs
    // ****************************************************************
    // Mask only hides reporting; status keeps its own value upstream
    assign pend = I_STATUS_BITS & enable_mask & VALID; // see R21

    always_comb begin
        next_vector_index = prio_index; // see R6 R7 R24
        next_irq          = output_gate && (pend != 32'h0000_0000); // see R22 R10
        next_irq_fast     = next_irq && mode_select[prio_index[4:0]];
        next_irq_addr     = 32'h0000_0000;
        if (next_irq_fast) begin
            next_irq_addr = tbl.sel_addr; // see R18
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            awready      <= 1'b0;
            bvalid       <= 1'b0;
            bresp        <= iev_pkg::RESP_OKAY;
            arready      <= 1'b0;
            rvalid       <= 1'b0;
            rdata        <= 32'h0000_0000;
            rresp        <= iev_pkg::RESP_OKAY;
            enable_mask  <= iev_pkg::RST_ENABLE_MASK;
            mode_select  <= iev_pkg::RST_MODE;
            output_gate  <= iev_pkg::RST_GATE; // see R9
            hw_input_arm <= iev_pkg::RST_ARM; // see R9 R11
            vector_index <= iev_pkg::RST_VEC_INDEX;
            irq          <= 1'b0;
            irq_fast     <= 1'b0;
            irq_addr     <= 32'h0000_0000;
        end else begin
            awready      <= next_awready;
            bvalid       <= next_bvalid;
            bresp        <= next_bresp;
            arready      <= next_arready;
            rvalid       <= next_rvalid;
            rdata        <= next_rdata;
            rresp        <= next_rresp;
            enable_mask  <= next_enable_mask;
            mode_select  <= next_mode_select;
            output_gate  <= next_output_gate;
            hw_input_arm <= next_hw_input_arm;
            vector_index <= next_vector_index;
            irq          <= next_irq;
            irq_fast     <= next_irq_fast;
            irq_addr     <= next_irq_addr;
        end
    end

    assign O_S_AXI_AWREADY = awready;
    assign O_S_AXI_WREADY  = awready;
    assign O_S_AXI_BVALID  = bvalid;
    assign O_S_AXI_BRESP   = bresp;
    assign O_S_AXI_ARREADY = arready;
    assign O_S_AXI_RVALID  = rvalid;
    assign O_S_AXI_RDATA   = rdata;
    assign O_S_AXI_RRESP   = rresp;
    assign O_IRQ           = irq;
    assign O_IRQ_FAST      = irq_fast;
    assign O_IRQ_ADDR      = irq_addr;
    // Capture logic ignores hardware inputs and takes software test writes while low
    assign O_HW_INPUT_ARM  = hw_input_arm; // see R11
endmodule

//--- iev_ctrl_properties.sv
`timescale 1ns/1ps
module iev_properties (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // Register bus
    input  wire logic        I_S_AXI_AWVALID,
    input  wire logic        I_S_AXI_WVALID,
    input  wire logic        O_S_AXI_AWREADY,
    input  wire logic        O_S_AXI_WREADY,
    input  wire logic        O_S_AXI_BVALID,
    input  wire logic        I_S_AXI_ARVALID,
    input  wire logic        O_S_AXI_ARREADY,
    input  wire logic        O_S_AXI_RVALID,
    // Interrupt side
    input  wire logic [31:0] I_STATUS_BITS,
    input  wire logic        O_IRQ,
    input  wire logic        O_IRQ_FAST,
    input  wire logic [31:0] O_IRQ_ADDR,
    input  wire logic        O_HW_INPUT_ARM
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    chk_write_taken: assert property (
        I_S_AXI_AWVALID && I_S_AXI_WVALID && !O_S_AXI_AWREADY && !O_S_AXI_BVALID
        |=> O_S_AXI_AWREADY && O_S_AXI_BVALID) else $error("write not answered");
    chk_ready_pair: assert property (
        $rose(O_S_AXI_AWREADY) |-> O_S_AXI_WREADY && O_S_AXI_BVALID)
        else $error("write ready without response");
    chk_read_taken: assert property (
        I_S_AXI_ARVALID && !O_S_AXI_ARREADY && !O_S_AXI_RVALID
        |=> O_S_AXI_ARREADY && O_S_AXI_RVALID) else $error("read not answered");
    chk_ar_pulse: assert property (
        O_S_AXI_ARREADY |=> !O_S_AXI_ARREADY) else $error("read ready too long");
    chk_idle_no_irq: assert property (
        $past(I_STATUS_BITS) == 32'h0000_0000 |-> !O_IRQ) else $error("request without cause");
    chk_fast_has_irq: assert property (
        O_IRQ_FAST |-> O_IRQ) else $error("fast flag without request");
    chk_normal_addr_zero: assert property (
        !O_IRQ_FAST |-> O_IRQ_ADDR == 32'h0000_0000) else $error("address outside fast mode");
    chk_arm_sticky: assert property (
        O_HW_INPUT_ARM |=> O_HW_INPUT_ARM) else $error("arm bit cleared");
endmodule

//--- iev_proc_model.sv
`timescale 1ns/1ps
module iev_proc_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Request from the controller
    input  wire logic        i_irq,
    input  wire logic        i_irq_fast,
    input  wire logic [31:0] i_irq_addr,
    // Address the core would jump to
    output logic      [31:0] o_vec_addr
);
    logic taken;

    // Latch once per fast request, as a core does when it enters the handler
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            taken      <= 1'b0;
            o_vec_addr <= 32'h0000_0000;
        end else if (i_irq_fast && !taken) begin
            taken      <= 1'b1;
            o_vec_addr <= i_irq_addr;
        end else if (!i_irq) begin
            taken      <= 1'b0;
        end
    end
endmodule

//--- interrupt_enable_vector_regs_tb.sv
`timescale 1ns/1ps
module interrupt_enable_vector_regs_tb;
    localparam int N = iev_pkg::DEF_HW_COUNT + iev_pkg::DEF_SW_COUNT;
    logic        clk, rst_n, awvalid, wvalid, bvalid, arvalid, rvalid;
    logic        awready, wready, arready, irq, irq_fast, arm;
    logic [8:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, status, irq_addr, vec_addr, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          num_errors = 0;
    int          checks = 0;

    iev_ctrl dut (.I_CLK(clk), .I_RST_N(rst_n), .I_S_AXI_AWADDR(awaddr),
        .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata),
        .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready),
        .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(1'b1),
        .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready),
        .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid),
        .I_S_AXI_RREADY(1'b1), .I_STATUS_BITS(status), .O_IRQ(irq),
        .O_IRQ_FAST(irq_fast), .O_IRQ_ADDR(irq_addr), .O_HW_INPUT_ARM(arm));
    iev_proc_model u_proc (.i_clk(clk), .i_rst_n(rst_n), .i_irq(irq),
        .i_irq_fast(irq_fast), .i_irq_addr(irq_addr), .o_vec_addr(vec_addr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ran_out();
        num_errors++;
        $display("wrong value at %0t: handshake wait ran out", $time);
        end_of_test();
    endtask

    // Valids stay up until ready is sampled; BREADY and RREADY are held high
    task automatic wr(input logic [8:0] a, input logic [31:0] v, input logic [1:0] rsp);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 20 && !(awready && bvalid); n++) @(posedge clk);
        if (n == 20) ran_out();
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        check(32'(bresp), 32'(rsp));
    endtask

    task automatic rd(input logic [8:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 20 && !(arready && rvalid); n++) @(posedge clk);
        if (n == 20) ran_out();
        arvalid <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
        rd(a);
        check(d, exp);
    endtask

    // Outputs are registered, so give the change three edges to land
    task automatic stat(input logic [31:0] v);
        @(posedge clk);
        status <= v;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        rdc(iev_pkg::OFF_ENABLE_MASK, iev_pkg::RST_ENABLE_MASK);
        rdc(iev_pkg::OFF_MASTER, 32'h0000_0000);
        rdc(iev_pkg::OFF_MODE, iev_pkg::RST_MODE);
        rdc(iev_pkg::OFF_TABLE_BASE, iev_pkg::RST_TABLE);
        rdc(iev_pkg::OFF_VEC_INDEX, iev_pkg::IDLE_VEC_INDEX);
        $display("test reset values done");
    endtask

    task automatic t_set_clear();
        wr(iev_pkg::OFF_SET_LOC, 32'hFFFF_FFFF, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_ENABLE_MASK, 32'h0000_003F);
        wr(iev_pkg::OFF_CLEAR_LOC, 32'h0000_0005, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_ENABLE_MASK, 32'h0000_003A);
        wr(iev_pkg::OFF_SET_LOC, 32'h0000_0000, iev_pkg::RESP_OKAY);
        wr(iev_pkg::OFF_CLEAR_LOC, 32'hFFFF_FFC0, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_ENABLE_MASK, 32'h0000_003A);
        wr(iev_pkg::OFF_SET_LOC, 32'h0000_0005, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_ENABLE_MASK, 32'h0000_003F);
        $display("test set and clear done");
    endtask

    task automatic t_priority();
        for (int i = 0; i < N; i++) begin
            stat((32'hFFFF_FFFF << i) & 32'h0000_003F);
            rdc(iev_pkg::OFF_VEC_INDEX, 32'(i));
        end
        stat(32'h0000_0000);
        rdc(iev_pkg::OFF_VEC_INDEX, iev_pkg::IDLE_VEC_INDEX);
        wr(iev_pkg::OFF_CLEAR_LOC, 32'h0000_0001, iev_pkg::RESP_OKAY);
        stat(32'h0000_0003);
        rdc(iev_pkg::OFF_VEC_INDEX, 32'h0000_0001);
        stat(32'h0000_0001);
        rdc(iev_pkg::OFF_VEC_INDEX, iev_pkg::IDLE_VEC_INDEX);
        wr(iev_pkg::OFF_SET_LOC, 32'h0000_0001, iev_pkg::RESP_OKAY);
        $display("test priority done");
    endtask

    task automatic t_fast();
        // Table is written with the gate closed
        for (int i = 0; i < 8; i++) begin
            wr(9'(iev_pkg::OFF_TABLE_BASE + 4 * i), 32'h0000_1000 | (i << 4),
               iev_pkg::RESP_OKAY);
        end
        for (int i = 0; i < 8; i++) begin
            rdc(9'(iev_pkg::OFF_TABLE_BASE + 4 * i),
                (i < N) ? (32'h0000_1000 | (i << 4)) : 32'h0000_0000);
        end
        wr(iev_pkg::OFF_MODE, 32'hFFFF_FFFF, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_MODE, 32'h0000_003F);
        stat(32'h0000_0004);
        check(32'(irq), 32'h0000_0000);
        wr(iev_pkg::OFF_MASTER, 32'h0000_0001, iev_pkg::RESP_OKAY);
        stat(32'h0000_0004);
        check(32'(irq), 32'h0000_0001);
        check(irq_addr, 32'h0000_1020);
        check(vec_addr, 32'h0000_1020);
        for (int i = 0; i < N; i++) begin
            stat((32'h0000_0001 << i) | 32'h0000_0020);
            check(irq_addr, 32'h0000_1000 | (i << 4));
        end
        wr(iev_pkg::OFF_MODE, 32'h0000_0000, iev_pkg::RESP_OKAY);
        stat(32'h0000_0020);
        check({irq, irq_fast, irq_addr[29:0]}, 32'h8000_0000);
        wr(iev_pkg::OFF_MASTER, 32'hFFFF_FFFD, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_MASTER, 32'h0000_0001);
        wr(iev_pkg::OFF_MASTER, 32'h0000_0000, iev_pkg::RESP_OKAY);
        stat(32'h0000_0020);
        check(32'(irq), 32'h0000_0000);
        $display("test fast mode done");
    endtask

    task automatic t_arm();
        wr(iev_pkg::OFF_MASTER, 32'h0000_0002, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_MASTER, 32'h0000_0002);
        check(32'(arm), 32'h0000_0001);
        wr(iev_pkg::OFF_MASTER, 32'h0000_0000, iev_pkg::RESP_OKAY);
        rdc(iev_pkg::OFF_MASTER, 32'h0000_0002);
        rd(9'h000);
        check({d[29:0], r}, 32'(iev_pkg::RESP_SLVERR));
        wr(9'h004, 32'hFFFF_FFFF, iev_pkg::RESP_SLVERR);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(iev_pkg::OFF_MASTER, 32'h0000_0000);
        check(32'(arm), 32'h0000_0000);
        $display("test arm done");
    endtask

    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {awaddr, araddr, wdata, status} = '0;
        wstrb = 4'hF;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_set_clear();
        t_priority();
        t_fast();
        t_arm();
        end_of_test();
    end
endmodule

bind iev_ctrl iev_properties u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .I_S_AXI_WVALID(I_S_AXI_WVALID),
    .O_S_AXI_AWREADY(O_S_AXI_AWREADY), .O_S_AXI_WREADY(O_S_AXI_WREADY),
    .O_S_AXI_BVALID(O_S_AXI_BVALID), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
    .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RVALID(O_S_AXI_RVALID),
    .I_STATUS_BITS(I_STATUS_BITS), .O_IRQ(O_IRQ), .O_IRQ_FAST(O_IRQ_FAST),
    .O_IRQ_ADDR(O_IRQ_ADDR), .O_HW_INPUT_ARM(O_HW_INPUT_ARM));
